// ==== hdl/i2c_status_and_address_mask.sv ====
// Status flags and slave address masking of a two-wire bus controller
`timescale 1ns/1ps
`include "i2c_stat_consts.svh"

module i2c_status_and_address_mask #(
  parameter int MASK_W = `MASK_WIDTH
) (
  input  wire logic                      clk_in,
  input  wire logic                      rst_b_in,
  input  wire logic [3:0]                addr_in,
  input  wire logic [15:0]               wdata_in,
  input  wire logic                      wr_in,
  input  wire logic                      rd_in,
  output logic      [15:0]               rdata_out,
  input  wire logic                      module_busy_in,
  input  wire logic                      master_tx_start_in,
  input  wire logic                      slave_ack_done_in,
  input  wire logic                      slave_ack_bit_in,
  input  wire logic                      tx_done_in,
  input  wire logic                      collision_in,
  input  wire logic                      start_det_in,
  input  wire logic                      stop_det_in,
  input  wire logic                      byte_done_in,
  input  wire logic                      byte_is_addr_in,
  input  wire logic                      ten_bit_second_in,
  input  wire i2c_stat_pkg::byte_t       shift_byte_in,
  input  wire i2c_stat_pkg::byte_t       first_addr_byte_in,
  output logic                           rx_pulse_out,
  output logic                           addr_match_out,
  output logic                           tx_load_out,
  output i2c_stat_pkg::byte_t            tx_data_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rst_s1_r;
  logic rst_s2_r;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  wire rst_b = rst_s2_r;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic                    ack_status_flag_r;
  logic                    master_tx_in_progress_r;
  logic                    collision_flag_r;
  logic                    general_call_received_r;
  logic                    ten_bit_match_flag_r;
  logic                    write_collision_flag_r;
  logic                    receive_overflow_flag_r;
  logic                    data_addr_r;
  logic                    stop_seen_r;
  logic                    start_seen_r;
  logic                    read_write_r;
  logic                    receive_buffer_full_flag_r;
  logic                    transmit_buffer_full_flag_r;
  logic [MASK_W-1:0]       address_mask_bits_r;
  i2c_stat_pkg::byte_t     receive_buffer_r;
  i2c_stat_pkg::byte_t     transmit_register_r;
  i2c_stat_pkg::addr10_t   stored_slave_address_r;
  logic                    ten_bit_address_select_r;
  logic                    tx_load_r;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  wire sel_status = (addr_in == `REG_STATUS);
  wire sel_mask   = (addr_in == `REG_MASK);
  wire sel_rx     = (addr_in == `REG_RX_BUFFER);
  wire sel_tx     = (addr_in == `REG_TX_REGISTER);
  wire sel_sadr   = (addr_in == `REG_SLAVE_ADDR);
  wire sel_ctrl   = (addr_in == `REG_CONTROL);

  wire wr_status  = wr_in && sel_status;
  wire wr_mask    = wr_in && sel_mask;
  wire wr_tx      = wr_in && sel_tx;
  wire rd_rx      = rd_in && sel_rx;

  // Write collision: transmit write while busy is discarded
  // drop busy write
  wire tx_accept  = wr_tx && !module_busy_in;
  wire tx_reject  = wr_tx && module_busy_in;

  ////////////////////////////////////////////////////////////////////////////
  // Address compare
  // Ten-bit address byte 1 is 11110 A9 A8 R/W, byte 2 carries A7..A0
  // address width select
  wire [MASK_W-1:0] mask_eff = ten_bit_address_select_r ?
                               address_mask_bits_r :
                               {3'h0, address_mask_bits_r[6:0]};
  wire [9:0] rx_addr = ten_bit_address_select_r ?
                       {first_addr_byte_in[2:1], shift_byte_in} :
                       {3'h0, shift_byte_in[7:1]};
  wire [9:0] own_addr = ten_bit_address_select_r ?
                        stored_slave_address_r :
                        {3'h0, stored_slave_address_r[6:0]};
  wire addr_eq = (((rx_addr ^ own_addr) & ~mask_eff) == 10'h000);
  wire gen_call = !ten_bit_address_select_r && !ten_bit_second_in &&
                  (shift_byte_in[7:1] == `GEN_CALL_ADDR);

  wire addr_evt   = byte_done_in && byte_is_addr_in;
  wire match_evt  = addr_evt && addr_eq &&
                    (ten_bit_address_select_r == ten_bit_second_in);
  wire gc_evt     = addr_evt && gen_call;
  wire data_evt   = byte_done_in && !byte_is_addr_in;
  wire rx_xfer    = data_evt || match_evt || gc_evt;
  wire rw_bit     = ten_bit_second_in ? first_addr_byte_in[0] :
                                        shift_byte_in[0];

  ////////////////////////////////////////////////////////////////////////////
  // Master transmit flags
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      ack_status_flag_r       <= 1'b0;
      master_tx_in_progress_r <= 1'b0;
    end else begin
      if (slave_ack_done_in) begin
        ack_status_flag_r <= slave_ack_bit_in;
      end
      if (master_tx_start_in) begin
        master_tx_in_progress_r <= 1'b1;
      end else if (slave_ack_done_in) begin
        master_tx_in_progress_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky flags, set wins over software clear
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      collision_flag_r        <= 1'b0;
      write_collision_flag_r  <= 1'b0;
      receive_overflow_flag_r <= 1'b0;
    end else begin
      if (collision_in) begin
        collision_flag_r <= 1'b1;
      end else if (wr_status && !wdata_in[`BIT_COLLISION]) begin
        collision_flag_r <= 1'b0;
      end
      if (tx_reject) begin
        write_collision_flag_r <= 1'b1;
      end else if (wr_status && !wdata_in[`BIT_WRITE_COLL]) begin
        write_collision_flag_r <= 1'b0;
      end
      if (rx_xfer && receive_buffer_full_flag_r && !rd_rx) begin
        receive_overflow_flag_r <= 1'b1;
      end else if (wr_status && !wdata_in[`BIT_RX_OVERFLOW]) begin
        receive_overflow_flag_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus condition and slave flags
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      general_call_received_r <= 1'b0;
      ten_bit_match_flag_r    <= 1'b0;
      start_seen_r            <= 1'b0;
      stop_seen_r             <= 1'b0;
      data_addr_r             <= 1'b0;
      read_write_r            <= 1'b0;
    end else begin
      if (gc_evt) begin
        general_call_received_r <= 1'b1;
      end else if (stop_det_in) begin
        general_call_received_r <= 1'b0;
      end
      if (match_evt && ten_bit_second_in) begin
        ten_bit_match_flag_r <= 1'b1;
      end else if (stop_det_in) begin
        ten_bit_match_flag_r <= 1'b0;
      end
      if (start_det_in) begin
        start_seen_r <= 1'b1;
        stop_seen_r  <= 1'b0;
      end else if (stop_det_in) begin
        start_seen_r <= 1'b0;
        stop_seen_r  <= 1'b1;
      end
      if (match_evt || gc_evt) begin
        data_addr_r <= 1'b0;
      end else if (data_evt) begin
        data_addr_r <= 1'b1;
      end
      if (match_evt) begin
        read_write_r <= rw_bit;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Buffers and software registers
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      receive_buffer_full_flag_r  <= 1'b0;
      transmit_buffer_full_flag_r <= 1'b0;
      receive_buffer_r            <= 8'h00;
      transmit_register_r         <= 8'h00;
      tx_load_r                   <= 1'b0;
    end else begin
      tx_load_r <= tx_accept;
      if (rx_xfer) begin
        receive_buffer_r           <= shift_byte_in;
        receive_buffer_full_flag_r <= 1'b1;
      end else if (rd_rx) begin
        receive_buffer_full_flag_r <= 1'b0;
      end
      if (tx_accept) begin
        transmit_register_r         <= wdata_in[7:0];
        transmit_buffer_full_flag_r <= 1'b1;
      end else if (tx_done_in) begin
        transmit_buffer_full_flag_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      address_mask_bits_r      <= `MASK_RESET;
      stored_slave_address_r   <= 10'h000;
      ten_bit_address_select_r <= 1'b0;
    end else begin
      if (wr_mask) begin
        address_mask_bits_r <= wdata_in[MASK_W-1:0];
      end
      if (wr_in && sel_sadr) begin
        stored_slave_address_r <= wdata_in[9:0];
      end
      if (wr_in && sel_ctrl) begin
        ten_bit_address_select_r <= wdata_in[`CTRL_TEN_BIT_SEL];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  i2c_stat_pkg::reg_word_t status_word;
  always_comb begin
    status_word                     = `STATUS_RESET;
    status_word[`BIT_ACK_STATUS]    = ack_status_flag_r;
    status_word[`BIT_MTX_PROGRESS]  = master_tx_in_progress_r;
    status_word[`BIT_COLLISION]     = collision_flag_r;
    status_word[`BIT_GEN_CALL]      = general_call_received_r;
    status_word[`BIT_TEN_BIT_MATCH] = ten_bit_match_flag_r;
    status_word[`BIT_WRITE_COLL]    = write_collision_flag_r;
    status_word[`BIT_RX_OVERFLOW]   = receive_overflow_flag_r;
    status_word[`BIT_DATA_ADDR]     = data_addr_r;
    status_word[`BIT_STOP_SEEN]     = stop_seen_r;
    status_word[`BIT_START_SEEN]    = start_seen_r;
    status_word[`BIT_READ_WRITE]    = read_write_r;
    status_word[`BIT_RX_FULL]       = receive_buffer_full_flag_r;
    status_word[`BIT_TX_FULL]       = transmit_buffer_full_flag_r;
  end

  wire [15:0] rd_mux =
    sel_status ? status_word :
    sel_mask   ? {6'h00, address_mask_bits_r} :
    sel_rx     ? {8'h00, receive_buffer_r} :
    sel_tx     ? {8'h00, transmit_register_r} :
    sel_sadr   ? {6'h00, stored_slave_address_r} :
    sel_ctrl   ? {15'h0000, ten_bit_address_select_r} :
                 16'h0000;

  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      rdata_out <= 16'h0000;
    end else begin
      rdata_out <= rd_in ? rd_mux : 16'h0000;
    end
  end

  assign rx_pulse_out   = rx_xfer;
  assign addr_match_out = match_evt || gc_evt;
  assign tx_load_out    = tx_load_r;
  assign tx_data_out    = transmit_register_r;

endmodule

// ==== inc/i2c_stat_consts.svh ====
// Offsets, field positions, reset values and widths for the status block
`ifndef I2C_STAT_CONSTS_SVH
`define I2C_STAT_CONSTS_SVH

`define REG_STATUS        4'h0
`define REG_MASK          4'h1
`define REG_RX_BUFFER     4'h2
`define REG_TX_REGISTER   4'h3
`define REG_SLAVE_ADDR    4'h4
`define REG_CONTROL       4'h5

`define BIT_ACK_STATUS    15
`define BIT_MTX_PROGRESS  14
`define BIT_COLLISION     10
`define BIT_GEN_CALL      9
`define BIT_TEN_BIT_MATCH 8
`define BIT_WRITE_COLL    7
`define BIT_RX_OVERFLOW   6
`define BIT_DATA_ADDR     5
`define BIT_STOP_SEEN     4
`define BIT_START_SEEN    3
`define BIT_READ_WRITE    2
`define BIT_RX_FULL       1
`define BIT_TX_FULL       0

`define CTRL_TEN_BIT_SEL  0

`define MASK_WIDTH        10
`define STATUS_RESET      16'h0000
`define MASK_RESET        10'h000
`define GEN_CALL_ADDR     7'h00
`define TEN_BIT_PREFIX    5'h1E

`endif

// ==== inc/i2c_stat_pkg.sv ====
// Types shared by the status block
package i2c_stat_pkg;
  typedef logic [15:0] reg_word_t;
  typedef logic [7:0]  byte_t;
  typedef logic [9:0]  addr10_t;
endpackage

// ==== verif/i2c_status_and_address_mask_checker.sv ====
// Port assertions for the status and mask block
`timescale 1ns/1ps
`include "i2c_stat_consts.svh"

module i2c_status_and_address_mask_checker (
  input wire logic                clk_in,
  input wire logic                rst_b_in,
  input wire logic [3:0]          addr_in,
  input wire logic [15:0]         wdata_in,
  input wire logic                wr_in,
  input wire logic                rd_in,
  input wire logic [15:0]         rdata_out,
  input wire logic                module_busy_in,
  input wire logic                master_tx_start_in,
  input wire logic                slave_ack_done_in,
  input wire logic                slave_ack_bit_in,
  input wire logic                collision_in,
  input wire logic                start_det_in,
  input wire logic                stop_det_in,
  input wire logic                byte_done_in,
  input wire logic                byte_is_addr_in,
  input wire logic                rx_pulse_out,
  input wire logic                tx_load_out,
  input wire i2c_stat_pkg::byte_t tx_data_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  wire rd_st = rd_in && addr_in == `REG_STATUS;
  wire tx_wr = wr_in && addr_in == `REG_TX_REGISTER;
  property p_rx; byte_done_in && !byte_is_addr_in |-> rx_pulse_out;
  endproperty
  a_rx: assert property (p_rx) else $error("no receive pulse");
  property p_load; tx_wr && !module_busy_in |=> tx_load_out &&
    tx_data_out == $past(wdata_in[7:0]); endproperty
  a_load: assert property (p_load) else $error("tx load");
  property p_refuse; tx_wr && module_busy_in |=> !tx_load_out &&
    $stable(tx_data_out); endproperty
  a_refuse: assert property (p_refuse) else $error("busy write");
  property p_wcol; tx_wr && module_busy_in ##1 !wr_in ##1 rd_st |=>
    rdata_out[7]; endproperty
  a_wcol: assert property (p_wcol) else $error("write coll");
  property p_mask; rd_in && addr_in == `REG_MASK |=>
    rdata_out[15:10] == 6'h00; endproperty
  a_mask: assert property (p_mask) else $error("mask upper");
  property p_gap; rd_st |=> rdata_out[13:11] == 3'h0; endproperty
  a_gap: assert property (p_gap) else $error("status gap");
  property p_stop; stop_det_in && !start_det_in ##1 !start_det_in ##1
    rd_st && !start_det_in |=> rdata_out[4] && !rdata_out[3]; endproperty
  a_stop: assert property (p_stop) else $error("stop bits");
  property p_start; start_det_in ##1 !stop_det_in ##1 rd_st &&
    !stop_det_in |=> rdata_out[3] && !rdata_out[4]; endproperty
  a_start: assert property (p_start) else $error("start bits");
  property p_ack; slave_ack_done_in && !master_tx_start_in ##1
    !slave_ack_done_in && !master_tx_start_in ##1 rd_st |=>
    rdata_out[15] == $past(slave_ack_bit_in, 3) && !rdata_out[14];
  endproperty
  a_ack: assert property (p_ack) else $error("ack status");
  property p_coll; collision_in ##1 !wr_in ##1 rd_st |=> rdata_out[10];
  endproperty
  a_coll: assert property (p_coll) else $error("collision");
endmodule

bind i2c_status_and_address_mask i2c_status_and_address_mask_checker chk (
  .clk_in             (clk_in),
  .rst_b_in           (rst_b_in),
  .addr_in            (addr_in),
  .wdata_in           (wdata_in),
  .wr_in              (wr_in),
  .rd_in              (rd_in),
  .rdata_out          (rdata_out),
  .module_busy_in     (module_busy_in),
  .master_tx_start_in (master_tx_start_in),
  .slave_ack_done_in  (slave_ack_done_in),
  .slave_ack_bit_in   (slave_ack_bit_in),
  .collision_in       (collision_in),
  .start_det_in       (start_det_in),
  .stop_det_in        (stop_det_in),
  .byte_done_in       (byte_done_in),
  .byte_is_addr_in    (byte_is_addr_in),
  .rx_pulse_out       (rx_pulse_out),
  .tx_load_out        (tx_load_out),
  .tx_data_out        (tx_data_out)
);

// ==== verif/i2c_bus_model.sv ====
// Far-side bus and engine events seen by the status block
`timescale 1ns/1ps

module i2c_bus_model (
  input  wire logic           clk_in,
  output logic [9:0]          ev_out,
  output i2c_stat_pkg::byte_t byte_out,
  output i2c_stat_pkg::byte_t first_out,
  output logic                busy_out
);
  initial begin
    ev_out = 10'h000;
    byte_out = 8'h5A;
    first_out = 8'h00;
    busy_out = 1'b0;
  end
  task automatic put(input logic [9:0] v, input i2c_stat_pkg::byte_t d,
                     input i2c_stat_pkg::byte_t f);
    @(posedge clk_in);
    ev_out <= v;
    byte_out <= d;
    first_out <= f;
  endtask
  task automatic drop();
    @(posedge clk_in);
    ev_out <= 10'h000;
    // Released data: never show the stale byte
    byte_out <= ~byte_out;
  endtask
  task automatic busy(input logic b);
    @(posedge clk_in);
    busy_out <= b;
  endtask
endmodule

// ==== verif/i2c_status_and_address_mask_test.sv ====
// Self-checking bench for the status and mask block
`timescale 1ns/1ps
`include "i2c_stat_consts.svh"
`define CHK(g, e, w) begin total_checks++; if ((g) !== (e)) begin \
  fail_count++; $display("wrong value %s expected %h seen %h", w, e, g); \
  end end

module i2c_status_and_address_mask_test;
  logic clk_in = 1'b0, rst_b_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
  logic [3:0] addr_in = 4'h0;
  logic [15:0] wdata_in = 16'h0000, rdata_out, rv;
  logic [9:0] ev;
  wire master_tx_start_in, slave_ack_done_in, slave_ack_bit_in, tx_done_in;
  wire collision_in, start_det_in, stop_det_in, byte_done_in;
  wire byte_is_addr_in, ten_bit_second_in, module_busy_in;
  i2c_stat_pkg::byte_t shift_byte_in, first_addr_byte_in, tx_data_out, fv;
  logic rx_pulse_out, addr_match_out, tx_load_out, mt;
  int fail_count = 0, total_checks = 0, cycles = 0;
  assign {master_tx_start_in, slave_ack_done_in, slave_ack_bit_in, tx_done_in,
    collision_in, start_det_in, stop_det_in, byte_done_in, byte_is_addr_in,
    ten_bit_second_in} = ev;
  i2c_bus_model m (.clk_in(clk_in), .ev_out(ev), .byte_out(shift_byte_in),
    .first_out(first_addr_byte_in), .busy_out(module_busy_in));
  i2c_status_and_address_mask uut (
    .clk_in             (clk_in),
    .rst_b_in           (rst_b_in),
    .addr_in            (addr_in),
    .wdata_in           (wdata_in),
    .wr_in              (wr_in),
    .rd_in              (rd_in),
    .rdata_out          (rdata_out),
    .module_busy_in     (module_busy_in),
    .master_tx_start_in (master_tx_start_in),
    .slave_ack_done_in  (slave_ack_done_in),
    .slave_ack_bit_in   (slave_ack_bit_in),
    .tx_done_in         (tx_done_in),
    .collision_in       (collision_in),
    .start_det_in       (start_det_in),
    .stop_det_in        (stop_det_in),
    .byte_done_in       (byte_done_in),
    .byte_is_addr_in    (byte_is_addr_in),
    .ten_bit_second_in  (ten_bit_second_in),
    .shift_byte_in      (shift_byte_in),
    .first_addr_byte_in (first_addr_byte_in),
    .rx_pulse_out       (rx_pulse_out),
    .addr_match_out     (addr_match_out),
    .tx_load_out        (tx_load_out),
    .tx_data_out        (tx_data_out)
  );
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      stop_test();
    end
  end
  ////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 rv = rdata_out;
  endtask
  task automatic st(input logic [15:0] k, e, input string w);
    rd(`REG_STATUS);
    `CHK(rv & k, e, w)
  endtask
  task automatic evp(input logic [9:0] v, input logic [7:0] d);
    m.put(v, d, fv);
    #1 mt = addr_match_out;
    m.drop();
  endtask
  task automatic t_reset();
    st(16'hFFFF, 16'h0000, "status at reset");
    rd(`REG_MASK);
    `CHK(rv, 16'h0000, "mask at reset")
    $display("test reset done");
  endtask
  task automatic t_address();
    wr(`REG_MASK, 16'hFFFF);
    rd(`REG_MASK);
    `CHK(rv, 16'h03FF, "mask upper bits")
    wr(`REG_SLAVE_ADDR, 16'h0055);
    wr(`REG_MASK, 16'h0002);
    evp(10'h006, 8'hBB);
    `CHK(mt, 1'b0, "unmasked bit differs")
    rd(`REG_RX_BUFFER);
    evp(10'h006, 8'hAF);
    `CHK(mt, 1'b1, "masked bit differs")
    st(16'h0066, 16'h0006, "slave read address");
    evp(10'h004, 8'hC3);
    st(16'h0062, 16'h0062, "data over full buffer");
    rd(`REG_RX_BUFFER);
    `CHK(rv, 16'h00C3, "receive buffer")
    st(16'h0002, 16'h0000, "read clears full");
    wr(`REG_CONTROL, 16'h0001);
    wr(`REG_SLAVE_ADDR, 16'h02A5);
    wr(`REG_MASK, 16'h0000);
    fv = 8'hF5;
    evp(10'h007, 8'hA5);
    `CHK(mt, 1'b1, "ten-bit match")
    st(16'h0104, 16'h0104, "ten-bit read");
    wr(`REG_MASK, 16'h0200);
    fv = 8'hF0;
    evp(10'h007, 8'hA5);
    `CHK(mt, 1'b1, "ten-bit upper masked")
    evp(10'h008, 8'h00);
    st(16'h0318, 16'h0010, "stop clears");
    wr(`REG_CONTROL, 16'h0000);
    evp(10'h006, 8'h00);
    st(16'h0200, 16'h0200, "general call");
    evp(10'h010, 8'h00);
    st(16'h0018, 16'h0008, "start seen");
    evp(10'h008, 8'h00);
    st(16'h0200, 16'h0000, "stop clears call");
    $display("test address done");
  endtask
  task automatic t_master();
    evp(10'h200, 8'h00);
    st(16'hC000, 16'h4000, "transmit in progress");
    evp(10'h180, 8'h00);
    st(16'hC000, 16'h8000, "nack");
    evp(10'h100, 8'h00);
    st(16'hC000, 16'h0000, "ack");
    evp(10'h020, 8'h00);
    st(16'h0400, 16'h0400, "collision");
    st(16'h0400, 16'h0400, "collision holds");
    wr(`REG_STATUS, 16'h0000);
    st(16'h0400, 16'h0000, "collision cleared");
    $display("test master done");
  endtask
  task automatic t_transmit();
    wr(`REG_TX_REGISTER, 16'h003C);
    st(16'h0081, 16'h0001, "transmit full");
    m.busy(1'b1);
    wr(`REG_TX_REGISTER, 16'h00C3);
    st(16'h0081, 16'h0081, "write while busy");
    `CHK(tx_data_out, 8'h3C, "refused write")
    m.busy(1'b0);
    evp(10'h040, 8'h00);
    st(16'h0001, 16'h0000, "transmit done");
    wr(`REG_STATUS, 16'h0000);
    st(16'h0080, 16'h0000, "write coll cleared");
    $display("test transmit done");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    fv = 8'h00;
    repeat (5) @(posedge clk_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    t_reset();
    t_address();
    t_master();
    t_transmit();
    stop_test();
  end
endmodule
